// ==== shared/strap_mux_map.vh ====
// Constants for the strap sampling and pin multiplexing block.
`ifndef STRAP_MUX_MAP_VH
`define STRAP_MUX_MAP_VH
// ----------------------------------------------------------------------------
// Configuration modes
// ----------------------------------------------------------------------------
`define CFG_MODE_UART 2'h0
`define CFG_MODE_I2C 2'h1
`define CFG_MODE_SPI 2'h2
// ----------------------------------------------------------------------------
// Slave address
// ----------------------------------------------------------------------------
`define I2C_ADDR_UPPER 5'h08
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_HZ 125000000
`define UART_BAUD 115200
`define UART_DIV (`CLK_HZ / `UART_BAUD)
`define SETTLE_CYCLES 1024
`endif

// ==== hw/uart_tx_fixed.v ====
// Fixed-rate serial transmitter for processed data output.
`timescale 1ns/1ps
`default_nettype none
`include "strap_mux_map.vh"
module uart_tx_fixed #(
  parameter DIV = `UART_DIV
) (
  input wire clk,
  input wire rst,
  input wire [7:0] txData,
  input wire txValid,
  output wire txReady,
  output reg txLine
);
  reg [15:0] baudCnt_reg;
  reg [3:0] bitCnt_reg;
  reg [8:0] shift_reg;
  reg busy_reg;

  assign txReady = ~busy_reg;

  // --------------------------------------------------------------------------
  // Shifter: start bit, eight data bits LSB first, stop bit.
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      baudCnt_reg <= 16'h0000;
      bitCnt_reg <= 4'h0;
      shift_reg <= 9'h1FF;
      busy_reg <= 1'b0;
      txLine <= 1'b1;
    end
    else if (!busy_reg)
    begin
      txLine <= 1'b1;
      if (txValid)
      begin
        busy_reg <= 1'b1;
        shift_reg <= {1'b1, txData};
        txLine <= 1'b0;
        baudCnt_reg <= 16'h0000;
        bitCnt_reg <= 4'h0;
      end
    end
    else if (baudCnt_reg == DIV[15:0] - 16'h0001)
    begin
      baudCnt_reg <= 16'h0000;
      if (bitCnt_reg == 4'h9)
      begin
        busy_reg <= 1'b0;
        txLine <= 1'b1;
      end
      else
      begin
        txLine <= shift_reg[0];
        shift_reg <= {1'b1, shift_reg[8:1]};
        bitCnt_reg <= bitCnt_reg + 4'h1;
      end
    end
    else
    begin
      baudCnt_reg <= baudCnt_reg + 16'h0001;
    end
  end
endmodule // uart_tx_fixed
`default_nettype wire

// ==== hw/radar_strap_pin_mux.v ====
// Strap sampling and shared-pin routing for the radar sensor.
//
// Operation
// - While the active-low external reset is low, all logic returns to defaults.
// - Config straps decode low/low to UART, low/high to I2C, first strap high to SPI.
// - In I2C mode the slave address is 01000 followed by two sampled address straps.
// - The two address straps give four distinct addresses on one bus.
// - With detection enabled, the detect output is high while a target is present.
// - Detection is enabled by a register setting, not by a strap.
// - The data UART sends at a fixed 115200 baud.
// - The first config pin is I2C data, SPI data in, or UART receive by mode.
// - The second config pin is I2C clock, SPI clock, or UART transmit by mode.
// - SPI config mode uses a dedicated chip select pin and returns data on the first config strap pin.
// - For data output the device is SPI master driving select, clock and lane zero.
// - The second config strap and data-mode strap have internal pull-ups.
`timescale 1ns/1ps
`default_nettype none
`include "strap_mux_map.vh"
module radar_strap_pin_mux #(
  parameter SETTLE_CYCLES = `SETTLE_CYCLES,
  parameter UART_DIV = `UART_DIV
) (
  input wire clk,
  input wire rst,
  input wire ext_reset_n,
  input wire cfgDataIn,
  output reg cfgDataOut,
  output reg cfgDataOe,
  input wire cfgClkIn,
  output reg cfgClkOut,
  output reg cfgClkOe,
  input wire cfg_select_pin,
  input wire cfgReturnIn,
  output reg cfgReturnOut,
  output reg cfgReturnOe,
  input wire cfgStrapBIn,
  output wire cfgStrapBPullup,
  input wire dataUartIn,
  output wire dataUartOut,
  output wire dataUartOe,
  output wire dataUartPullup,
  input wire dataLane0In,
  output reg dataLane0Out,
  output wire dataLane0Oe,
  input wire target_detect_pin_in,
  output wire target_detect_pin,
  output wire targetDetectOe,
  output reg out_select_pin,
  output reg dataSpiClk,
  input wire detectEnable,
  input wire targetPresent,
  input wire i2cSdaDrive,
  input wire cfgTxData,
  input wire cfgMisoData,
  output wire cfgRxData,
  output wire cfgRxClk,
  output wire cfgRxSelect,
  input wire [7:0] outData,
  input wire outValid,
  output wire outReady,
  output wire [1:0] cfgMode,
  output wire [6:0] i2cAddress,
  output wire dataModeBoth,
  output wire settled
);
  localparam ST_SETTLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg state_reg;
  reg [15:0] settleCnt_reg;
  reg [1:0] resetSync_reg;
  reg [1:0] cfgASync_reg, cfgBSync_reg, modeSync_reg, addrHSync_reg, addrLSync_reg;
  reg [1:0] sdaSync_reg, sclSync_reg, selSync_reg;
  reg [1:0] cfgMode_reg;
  reg [6:0] i2cAddr_reg;
  reg dataMode_reg;
  reg [2:0] spiBit_reg;
  reg [7:0] spiShift_reg;
  reg spiBusy_reg;
  reg spiPhase_reg;
  reg detect_reg;
  wire intRst;
  wire uartTx;
  wire uartReady;
  wire startByte;

  // --------------------------------------------------------------------------
  // Reset and pin synchronisers
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    resetSync_reg <= {resetSync_reg[0], ext_reset_n};
    cfgASync_reg <= {cfgASync_reg[0], cfgReturnIn};
    cfgBSync_reg <= {cfgBSync_reg[0], cfgStrapBIn};
    modeSync_reg <= {modeSync_reg[0], dataUartIn};
    addrHSync_reg <= {addrHSync_reg[0], dataLane0In};
    addrLSync_reg <= {addrLSync_reg[0], target_detect_pin_in};
    sdaSync_reg <= {sdaSync_reg[0], cfgDataIn};
    sclSync_reg <= {sclSync_reg[0], cfgClkIn};
    selSync_reg <= {selSync_reg[0], cfg_select_pin};
  end

  assign intRst = rst | ~resetSync_reg[1];
  assign cfgStrapBPullup = 1'b1;
  assign dataUartPullup = 1'b1;

  // --------------------------------------------------------------------------
  // Settling and strap latch
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (intRst)
    begin
      state_reg <= ST_SETTLE;
      settleCnt_reg <= 16'h0000;
      cfgMode_reg <= `CFG_MODE_UART;
      i2cAddr_reg <= {`I2C_ADDR_UPPER, 2'h0};
      dataMode_reg <= 1'b1;
    end
    else
    begin
      case (state_reg)
        ST_SETTLE:
        begin
          if (settleCnt_reg == SETTLE_CYCLES[15:0] - 16'h0001)
          begin
            state_reg <= ST_RUN;
            if (cfgASync_reg[1])
              cfgMode_reg <= `CFG_MODE_SPI;
            else if (cfgBSync_reg[1])
              cfgMode_reg <= `CFG_MODE_I2C;
            else
              cfgMode_reg <= `CFG_MODE_UART;
            i2cAddr_reg <= {`I2C_ADDR_UPPER, addrHSync_reg[1], addrLSync_reg[1]};
            dataMode_reg <= modeSync_reg[1];
          end
          else
            settleCnt_reg <= settleCnt_reg + 16'h0001;
        end
        ST_RUN:
          state_reg <= ST_RUN;
        default:
          state_reg <= ST_SETTLE;
      endcase
    end
  end

  assign settled = state_reg;
  assign cfgMode = cfgMode_reg;
  assign i2cAddress = i2cAddr_reg;
  assign dataModeBoth = dataMode_reg;

  // --------------------------------------------------------------------------
  // Configuration pin routing
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (intRst || !state_reg)
    begin
      cfgDataOut <= 1'b0;
      cfgDataOe <= 1'b0;
      cfgClkOut <= 1'b1;
      cfgClkOe <= 1'b0;
      cfgReturnOut <= 1'b0;
      cfgReturnOe <= 1'b0;
    end
    else
    begin
      cfgDataOut <= 1'b0;
      cfgDataOe <= (cfgMode_reg == `CFG_MODE_I2C) & i2cSdaDrive;
      cfgClkOut <= cfgTxData;
      cfgClkOe <= (cfgMode_reg == `CFG_MODE_UART);
      cfgReturnOut <= cfgMisoData;
      cfgReturnOe <= (cfgMode_reg == `CFG_MODE_SPI) & ~selSync_reg[1];
    end
  end

  assign cfgRxData = sdaSync_reg[1];
  assign cfgRxClk = (cfgMode_reg == `CFG_MODE_UART) ? 1'b0 : sclSync_reg[1];
  assign cfgRxSelect = (cfgMode_reg == `CFG_MODE_SPI) ? selSync_reg[1] : 1'b1;

  // --------------------------------------------------------------------------
  // Processed data output: SPI master and UART
  // --------------------------------------------------------------------------
  assign startByte = state_reg & outValid & ~spiBusy_reg & uartReady;
  assign outReady = state_reg & ~spiBusy_reg & uartReady;

  always @(posedge clk)
  begin
    if (intRst)
    begin
      spiBusy_reg <= 1'b0;
      spiPhase_reg <= 1'b0;
      spiBit_reg <= 3'h0;
      spiShift_reg <= 8'h00;
      out_select_pin <= 1'b1;
      dataSpiClk <= 1'b0;
      dataLane0Out <= 1'b0;
    end
    else if (startByte)
    begin
      spiBusy_reg <= 1'b1;
      spiPhase_reg <= 1'b0;
      spiBit_reg <= 3'h7;
      spiShift_reg <= outData;
      out_select_pin <= 1'b0;
      dataLane0Out <= outData[7];
    end
    else if (spiBusy_reg)
    begin
      spiPhase_reg <= ~spiPhase_reg;
      dataSpiClk <= ~spiPhase_reg;
      if (spiPhase_reg)
      begin
        if (spiBit_reg == 3'h0)
        begin
          spiBusy_reg <= 1'b0;
          out_select_pin <= 1'b1;
        end
        else
        begin
          spiBit_reg <= spiBit_reg - 3'h1;
          spiShift_reg <= {spiShift_reg[6:0], 1'b0};
          dataLane0Out <= spiShift_reg[6];
        end
      end
    end
  end

  assign dataLane0Oe = state_reg;
  assign dataUartOut = uartTx;
  assign dataUartOe = state_reg & dataMode_reg;

  uart_tx_fixed #(
    .DIV(UART_DIV)
  ) dataUart (
    .clk(clk),
    .rst(intRst),
    .txData(outData),
    .txValid(startByte),
    .txReady(uartReady),
    .txLine(uartTx)
  );

  // --------------------------------------------------------------------------
  // Target detect
  // --------------------------------------------------------------------------
  always @(posedge clk)
  begin
    if (intRst)
      detect_reg <= 1'b0;
    else
      detect_reg <= targetPresent;
  end

  assign target_detect_pin = detect_reg;
  assign targetDetectOe = state_reg & detectEnable;
endmodule // radar_strap_pin_mux
`default_nettype wire

// ==== sim/board_strap_host.sv ====
// Board model that forces strap levels during settling and then lets go.
`timescale 1ns/1ps
`default_nettype none
module board_strap_host (
  input wire logic clk,
  input wire logic settled,
  input wire logic [4:0] strapSet,
  output var logic [4:0] pinLevel
);
  // Bit order is strap A, strap B, data mode, address high, address low.
  logic released;
  initial pinLevel = 5'h1F;
  initial released = 1'b0;
  always @(posedge clk)
  begin
    if (settled !== 1'b1)
    begin
      pinLevel <= strapSet;
      released <= 1'b0;
    end
    else if (!released)
    begin
      released <= 1'b1;
      // Pulled-up pins float high; the others show a stale inverse.
      pinLevel <= {~pinLevel[4], 2'b11, ~pinLevel[1:0]};
    end
  end
endmodule // board_strap_host
`default_nettype wire

// ==== sim/strap_mux_monitor.sv ====
// Checker for strap sampling and shared-pin routing.
`timescale 1ns/1ps
`default_nettype none
module strap_mux_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic ext_reset_n,
  input wire logic cfgDataOut,
  input wire logic cfgDataOe,
  input wire logic cfgClkOe,
  input wire logic target_detect_pin,
  input wire logic targetDetectOe,
  input wire logic out_select_pin,
  input wire logic dataSpiClk,
  input wire logic dataUartOut,
  input wire logic detectEnable,
  input wire logic targetPresent,
  input wire logic outValid,
  input wire logic outReady,
  input wire logic [1:0] cfgMode,
  input wire logic [6:0] i2cAddress,
  input wire logic settled
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !ext_reset_n);
  reset_defaults_a: assert property (disable iff (1'b0)
    rst ##1 rst |-> !settled && out_select_pin && cfgMode == 2'h0 && i2cAddress == 7'h20)
    else $error("reset defaults wrong");
  addr_upper_a: assert property (settled |-> i2cAddress[6:2] == 5'h08)
    else $error("address upper bits wrong");
  straps_hold_a: assert property (settled && $past(settled) |-> $stable({cfgMode, i2cAddress}))
    else $error("latched straps changed");
  detect_follow_a: assert property (
    targetDetectOe && $past(settled) |-> target_detect_pin == $past(targetPresent))
    else $error("detect output wrong");
  detect_enable_a: assert property (targetDetectOe == (settled && detectEnable))
    else $error("detect enable wrong");
  uart_route_a: assert property (cfgClkOe |-> $past(cfgMode) == 2'h0)
    else $error("transmit driven outside uart mode");
  sda_drain_a: assert property (
    cfgDataOe |-> !cfgDataOut && $past(cfgMode) == 2'h1)
    else $error("data line not open drain");
  frame_start_a: assert property (
    outValid && outReady |=> !out_select_pin && !dataUartOut)
    else $error("frame did not start");
  select_frame_a: assert property ($fell(out_select_pin) |-> !out_select_pin[*8])
    else $error("select frame too short");
  clock_idle_a: assert property (out_select_pin && $past(out_select_pin) |-> !dataSpiClk)
    else $error("serial clock moved while idle");
endmodule // strap_mux_monitor
bind radar_strap_pin_mux strap_mux_monitor mon (.clk(clk), .rst(rst),
  .ext_reset_n(ext_reset_n), .cfgDataOut(cfgDataOut), .cfgDataOe(cfgDataOe),
  .cfgClkOe(cfgClkOe), .target_detect_pin(target_detect_pin),
  .targetDetectOe(targetDetectOe), .out_select_pin(out_select_pin),
  .dataSpiClk(dataSpiClk), .dataUartOut(dataUartOut), .detectEnable(detectEnable),
  .targetPresent(targetPresent), .outValid(outValid), .outReady(outReady),
  .cfgMode(cfgMode), .i2cAddress(i2cAddress), .settled(settled));
`default_nettype wire

// ==== sim/radar_strap_pin_mux_tb.sv ====
// Self-checking bench for the strap and pin routing block.
`timescale 1ns/1ps
`default_nettype none
module radar_strap_pin_mux_tb;
  localparam int ST = 16;
  localparam int DV = 4;
  logic clk = 0, rst = 1, extN = 1, selN = 1, detEn = 0, tgt = 0;
  logic sdaDrv = 0, txD = 0, misoD = 0, outValid = 0, sdaIn = 0, sclIn = 0;
  logic rxD, rxC, rxS, l0Oe, pu1, pu2;
  logic [7:0] outData = 8'h00;
  logic [4:0] strapSet = 5'h1F;
  logic [4:0] pin;
  logic dOut, dOe, cOut, cOe, rOut, rOe, uOut, uOe, l0Out, det, detOe;
  logic csN, sclk, outReady, dataModeBoth, settled;
  logic [1:0] cfgMode;
  logic [6:0] i2cAddress;
  int failures = 0, checkCount = 0;
  bit [31:0] seed = 32'hF422E098;
  board_strap_host host (.clk(clk), .settled(settled), .strapSet(strapSet), .pinLevel(pin));
  radar_strap_pin_mux #(.SETTLE_CYCLES(ST), .UART_DIV(DV)) uut (
    .clk(clk), .rst(rst), .ext_reset_n(extN), .cfgDataIn(sdaIn), .cfgDataOut(dOut),
    .cfgDataOe(dOe), .cfgClkIn(sclIn), .cfgClkOut(cOut), .cfgClkOe(cOe),
    .cfg_select_pin(selN), .cfgReturnIn(pin[4]), .cfgReturnOut(rOut), .cfgReturnOe(rOe),
    .cfgStrapBIn(pin[3]), .cfgStrapBPullup(pu1), .dataUartIn(pin[2]), .dataUartOut(uOut),
    .dataUartOe(uOe), .dataUartPullup(pu2), .dataLane0In(pin[1]), .dataLane0Out(l0Out),
    .dataLane0Oe(l0Oe), .target_detect_pin_in(pin[0]), .target_detect_pin(det),
    .targetDetectOe(detOe), .out_select_pin(csN), .dataSpiClk(sclk), .detectEnable(detEn),
    .targetPresent(tgt), .i2cSdaDrive(sdaDrv), .cfgTxData(txD), .cfgMisoData(misoD),
    .cfgRxData(rxD), .cfgRxClk(rxC), .cfgRxSelect(rxS), .outData(outData), .outValid(outValid),
    .outReady(outReady), .cfgMode(cfgMode), .i2cAddress(i2cAddress),
    .dataModeBoth(dataModeBoth), .settled(settled));
  initial forever #4 clk = ~clk;
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checkCount++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && checkCount > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic boot(int i);
    int n;
    @(posedge clk);
    strapSet <= {i[1], i[0], 1'b1, i[2], i[0] ^ i[2]};
    if (i[0]) extN <= 0;
    else rst <= 1;
    repeat (4) @(posedge clk);
    check("resetSettled", 0, settled);
    extN <= 1;
    rst <= 0;
    n = 0;
    while (settled !== 1'b1 && n < ST + 20)
    begin
      @(negedge clk);
      n++;
    end
    check("settled", 1, settled);
  endtask
  task automatic send(logic [7:0] b);
    logic [7:0] s, u;
    logic ok;
    int n;
    @(posedge clk);
    outData <= b;
    outValid <= 1;
    n = 0;
    ok = 0;
    while (ok !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      ok = outReady;
      n++;
      @(posedge clk);
    end
    outValid <= 0;
    check("ready", 1, ok);
    fork
      for (int k = 7; k >= 0; k--)
      begin
        @(posedge sclk);
        s[k] = l0Out;
      end
      begin
        repeat (1 + DV / 2) @(posedge clk);
        for (int k = 0; k < 8; k++)
        begin
          repeat (DV) @(posedge clk);
          u[k] = uOut;
        end
      end
    join
    check("spiByte", b, s);
    check("uartByte", b, u);
  endtask
  initial
  begin
    #100000;
    failures++;
    complete_run();
  end
  initial
  begin
    bit [31:0] r;
    int md;
    for (int i = 0; i < 8; i++)
    begin
      boot(i);
      md = i[1] ? 2 : (i[0] ? 1 : 0);
      check("mode", md, cfgMode);
      check("addr", {5'h08, i[2], i[0] ^ i[2]}, i2cAddress);
      check("dataMode", 1, dataModeBoth);
      r = rnd();
      @(posedge clk);
      {sdaIn, sclIn, txD, sdaDrv, misoD, selN, detEn, tgt} <= {r[25:24], r[5:0]};
      repeat (5) @(negedge clk);
      check("modeHold", md, cfgMode);
      check("rxData", sdaIn, rxD);
      check("rxClk", (md == 0) ? 1'b0 : sclIn, rxC);
      check("rxSelect", (md == 2) ? selN : 1'b1, rxS);
      check("lane0Oe", 1, l0Oe);
      check("pullups", 2'b11, {pu1, pu2});
      check("uartOe", 1, uOe);
      check("clkOe", md == 0, cOe);
      if (md == 0) check("clkOut", txD, cOut);
      check("dataOe", md == 1 && sdaDrv, dOe);
      check("retOe", md == 2 && !selN, rOe);
      if (md == 2 && !selN) check("retOut", misoD, rOut);
      check("detOe", detEn, detOe);
      if (detEn) check("detect", tgt, det);
      send(r[15:8]);
      send(r[23:16]);
    end
    complete_run();
  end
endmodule // radar_strap_pin_mux_tb
`default_nettype wire
